/* hw/servo_param_bank.sv */
// Functional notes
// - Speed-loop gain writable, 1 to 3000 Hz, reset value 40.
// - Integral time writable, 1.0 to 1000.0 ms in tenths, reset 20.0.
// - Integral limit percentage reaches speed loop only while separation enabled.
// - Integral separation enable holds only 0 or 1, reset disabled.
// - Alarm time 0 to 100, three counts per second, 100 disables alarm.
// - Vibration low-pass corner writable, 1 to 2000 Hz, reset 50.
// - Vibration high-pass corner writable, 10 to 2000 Hz, reset 100.
// - New station alias acts only after save to memory and power cycle.
// - Stored alias ignored while master assigns addresses by position.
// - Mode selector: 0 standalone test mode, 1 fieldbus mode, reset 1.
// - Spline type 0 joins segments with continuous acceleration.
// - Spline type 1 joins segments with continuous velocity.
// - Spline type 2 default, linear even division; selector accepts 0 to 3.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "servo_param_bank_cfg.svh"

module servo_param_bank #(
  parameter int VIB_TICK_CYCLES = `VIB_TICK_CYCLES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output servo_param_bank_pkg::axi_resp_t O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output servo_param_bank_pkg::axi_resp_t O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_VIB_DETECTED,
  input wire logic I_POSITION_ADDRESSING,
  input wire logic [7:0] I_NV_ALIAS,
  output logic O_NV_SAVE,
  output logic [7:0] O_NV_ALIAS,
  output logic [7:0] O_STATION_ADDR,
  output logic O_ALIAS_ADDR_VALID,
  output servo_param_bank_pkg::param_word_t O_TRACK_GAIN,
  output servo_param_bank_pkg::param_word_t O_TRACK_ITIME,
  output servo_param_bank_pkg::param_word_t O_ISEP_LIMIT_EFF,
  output servo_param_bank_pkg::param_word_t O_VIB_DETECT_FREQ,
  output servo_param_bank_pkg::param_word_t O_VIB_LOWPASS,
  output servo_param_bank_pkg::param_word_t O_VIB_HIGHPASS,
  output servo_param_bank_pkg::param_word_t O_VIB_THRESHOLD,
  output servo_param_bank_pkg::param_word_t O_VIB_SPEED_LEVEL,
  output logic O_VIB_ALARM,
  output logic O_FIELDBUS_MODE,
  output logic O_SPLINE_ACCEL_CONT,
  output logic O_SPLINE_VEL_CONT,
  output logic O_SPLINE_LINEAR,
  output logic O_IRQ
);
  import servo_param_bank_pkg::*;

  function automatic param_word_t reset_val(input logic [3:0] idx);
    case (idx)
      `IDX_TRACK_GAIN: reset_val = `RST_TRACK_GAIN;
      `IDX_TRACK_ITIME: reset_val = `RST_TRACK_ITIME;
      `IDX_ISEP_LIMIT: reset_val = `RST_ISEP_LIMIT;
      `IDX_ISEP_ENABLE: reset_val = `RST_ISEP_ENABLE;
      `IDX_VIB_ALARM_TIME: reset_val = `RST_VIB_ALARM_TIME;
      `IDX_VIB_DETECT_FREQ: reset_val = `RST_VIB_DETECT_FREQ;
      `IDX_VIB_LOWPASS: reset_val = `RST_VIB_LOWPASS;
      `IDX_VIB_HIGHPASS: reset_val = `RST_VIB_HIGHPASS;
      `IDX_VIB_THRESHOLD: reset_val = `RST_VIB_THRESHOLD;
      `IDX_VIB_SPEED_LEVEL: reset_val = `RST_VIB_SPEED_LEVEL;
      `IDX_STATION_ALIAS: reset_val = `RST_STATION_ALIAS;
      `IDX_FIELDBUS_MODE: reset_val = `RST_FIELDBUS_MODE;
      `IDX_SPLINE_TYPE: reset_val = `RST_SPLINE_TYPE;
      default: reset_val = 16'h0000;
    endcase
  endfunction

  // Range check on the merged word, values signed
  function automatic logic in_range(input logic [3:0] idx, input param_word_t val);
    logic signed [15:0] v;
    v = signed'(val);
    case (idx)
      `IDX_TRACK_GAIN: in_range = v >= `MIN_TRACK_GAIN && v <= `MAX_TRACK_GAIN;
      `IDX_TRACK_ITIME: in_range = v >= `MIN_TRACK_ITIME && v <= `MAX_TRACK_ITIME;
      `IDX_ISEP_LIMIT: in_range = v >= 16'sh0000 && v <= `MAX_PCT;
      `IDX_ISEP_ENABLE: in_range = v >= 16'sh0000 && v <= `MAX_FLAG;
      `IDX_VIB_ALARM_TIME: in_range = v >= 16'sh0000 && v <= `MAX_PCT;
      `IDX_VIB_DETECT_FREQ: in_range = v >= 16'sh0000 && v <= `MAX_FREQ;
      `IDX_VIB_LOWPASS: in_range = v >= 16'sh0001 && v <= `MAX_FREQ;
      `IDX_VIB_HIGHPASS: in_range = v >= `MIN_HIGHPASS && v <= `MAX_FREQ;
      `IDX_VIB_THRESHOLD: in_range = v >= 16'sh0000 && v <= `MAX_FREQ;
      `IDX_VIB_SPEED_LEVEL: in_range = v >= 16'sh0001 && v <= `MAX_SPEED_LEVEL;
      `IDX_STATION_ALIAS: in_range = v >= 16'sh0000 && v <= `MAX_STATION_ALIAS;
      `IDX_FIELDBUS_MODE: in_range = v >= 16'sh0000 && v <= `MAX_FLAG;
      `IDX_SPLINE_TYPE: in_range = v >= 16'sh0000 && v <= `MAX_SPLINE_TYPE;
      default: in_range = 1'b0;
    endcase
  endfunction

  function automatic logic is_param(input logic [7:0] addr);
    is_param = addr[7:2] < 6'(`NUM_PARAMS);
  endfunction

  param_word_t param_r [`NUM_PARAMS];
  logic [`ST_WIDTH-1:0] status_r;
  logic [`ST_WIDTH-1:0] mask_r;
  logic [`ST_WIDTH-1:0] status_set;
  logic [`ST_WIDTH-1:0] status_clr;
  logic [`ST_WIDTH-1:0] status_nxt;

  // AXI write path
  logic awready_r, wready_r, bvalid_r, aw_full_r, w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  axi_resp_t bresp_r;
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  axi_resp_t rresp_r;

  wire aw_take = I_AWVALID && awready_r;
  wire w_take = I_WVALID && wready_r;
  wire ar_take = I_ARVALID && arready_r;
  wire do_write = aw_full_r && w_full_r && !bvalid_r;
  wire [3:0] wr_idx = aw_addr_r[5:2];
  wire wr_param = is_param(aw_addr_r);
  wire [15:0] wr_old = wr_param ? param_r[wr_idx] : 16'h0000;
  wire [15:0] wr_merged = {w_strb_r[1] ? w_data_r[15:8] : wr_old[15:8],
                           w_strb_r[0] ? w_data_r[7:0] : wr_old[7:0]};
  wire wr_ok = wr_param && in_range(wr_idx, wr_merged);
  wire wr_ctrl = aw_addr_r == `ADDR_CTRL;
  wire wr_mask = aw_addr_r == `ADDR_MASK;
  wire wr_ro = aw_addr_r == `ADDR_STATUS || aw_addr_r == `ADDR_ALIAS_ACTIVE;
  wire wr_mapped = wr_param || wr_ctrl || wr_mask || wr_ro;
  wire wr_reject = do_write && wr_param && !wr_ok;
  wire save_alias = do_write && wr_ctrl && w_strb_r[0] && w_data_r[`CTRL_SAVE_ALIAS_BIT];
  wire [1:0] wr_resp = !wr_mapped ? `RESP_DECERR : (wr_param && !wr_ok) ? `RESP_SLVERR :
                       `RESP_OKAY;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      awready_r <= I_AWVALID && !awready_r && !aw_full_r && !bvalid_r;
      wready_r <= I_WVALID && !wready_r && !w_full_r && !bvalid_r;
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {I_AWADDR[7:2], 2'b00};
      end else if (do_write) begin
        aw_full_r <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB;
      end else if (do_write) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_resp;
    end else if (bvalid_r && I_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // Parameter store; rejected writes leave the old value
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < `NUM_PARAMS; i++) begin
        param_r[i] <= reset_val(4'(i));
      end
    end else if (do_write && wr_ok) begin
      param_r[wr_idx] <= wr_merged;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mask_r <= `RST_MASK;
    end else if (do_write && wr_mask && w_strb_r[0]) begin
      mask_r <= w_data_r[`ST_WIDTH-1:0];
    end
  end

  // AXI read path; status clears on its read
  wire [3:0] rd_idx = I_ARADDR[5:2];
  wire [7:0] rd_addr = {I_ARADDR[7:2], 2'b00};
  wire rd_param = is_param(rd_addr);
  wire rd_status = rd_addr == `ADDR_STATUS;
  wire rd_mask = rd_addr == `ADDR_MASK;
  wire rd_alias = rd_addr == `ADDR_ALIAS_ACTIVE;
  wire rd_ctrl = rd_addr == `ADDR_CTRL;
  wire rd_mapped = rd_param || rd_status || rd_mask || rd_alias || rd_ctrl;
  logic [7:0] alias_active_r;
  wire [31:0] rd_word = rd_param ? {16'h0000, param_r[rd_idx]} :
                        rd_status ? {29'h0, status_r} :
                        rd_mask ? {29'h0, mask_r} :
                        rd_alias ? {24'h000000, alias_active_r} : 32'h0000_0000;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else begin
      arready_r <= I_ARVALID && !arready_r && !rvalid_r;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_mapped ? `RESP_OKAY : `RESP_DECERR;
      end else if (rvalid_r && I_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Pin synchronisers; a change counts when stages two and three agree
  logic [2:0] vib_sync_r, pos_sync_r;
  logic vib_level_r, pos_level_r;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      vib_sync_r <= 3'h0;
      pos_sync_r <= 3'h0;
      vib_level_r <= 1'b0;
      pos_level_r <= 1'b0;
    end else begin
      vib_sync_r <= {vib_sync_r[1:0], I_VIB_DETECTED};
      pos_sync_r <= {pos_sync_r[1:0], I_POSITION_ADDRESSING};
      if (vib_sync_r[1] == vib_sync_r[2]) begin
        vib_level_r <= vib_sync_r[2];
      end
      if (pos_sync_r[1] == pos_sync_r[2]) begin
        pos_level_r <= pos_sync_r[2];
      end
    end
  end

  // Vibration persistence: one count per third of a second
  param_word_t alarm_time;
  assign alarm_time = param_r[`IDX_VIB_ALARM_TIME];
  wire alarm_off = alarm_time == `VIB_ALARM_OFF;
  logic [31:0] tick_cnt_r;
  logic [15:0] persist_r;
  logic vib_alarm_r;
  wire tick = tick_cnt_r == 32'(VIB_TICK_CYCLES - 1);
  wire vib_active = vib_level_r && !alarm_off;
  wire alarm_hit = vib_active && persist_r >= alarm_time;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt_r <= 32'h0000_0000;
      persist_r <= 16'h0000;
      vib_alarm_r <= 1'b0;
    end else begin
      if (!vib_active || tick) begin
        tick_cnt_r <= 32'h0000_0000;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
      if (!vib_active) begin
        persist_r <= 16'h0000;
      end else if (tick && !alarm_hit) begin
        persist_r <= persist_r + 16'h0001;
      end
      vib_alarm_r <= alarm_hit;
    end
  end

  // Alias: saved on command, adopted from memory after reset release
  logic alias_load_r, nv_save_r;
  logic [7:0] nv_alias_r;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      alias_load_r <= 1'b1;
      alias_active_r <= 8'h00;
      nv_save_r <= 1'b0;
      nv_alias_r <= 8'h00;
    end else begin
      alias_load_r <= 1'b0;
      if (alias_load_r) begin
        alias_active_r <= I_NV_ALIAS;
      end
      nv_save_r <= save_alias;
      if (save_alias) begin
        nv_alias_r <= param_r[`IDX_STATION_ALIAS][7:0];
      end
    end
  end

  // Sticky status; a set in the clearing cycle wins
  logic vib_alarm_d_r;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      vib_alarm_d_r <= 1'b0;
    end else begin
      vib_alarm_d_r <= vib_alarm_r;
    end
  end

  assign status_set = {save_alias, vib_alarm_r && !vib_alarm_d_r, wr_reject};
  assign status_clr = (ar_take && rd_status) ? {`ST_WIDTH{1'b1}} : {`ST_WIDTH{1'b0}};
  assign status_nxt = (status_r & ~status_clr) | status_set;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      status_r <= {`ST_WIDTH{1'b0}};
    end else begin
      status_r <= status_nxt;
    end
  end

  // Registered drive outputs
  logic irq_r, fb_mode_r, sp_acc_r, sp_vel_r, sp_lin_r, alias_valid_r;
  param_word_t isep_eff_r;
  logic [7:0] station_addr_r;
  spline_t spline_sel;
  assign spline_sel = spline_t'(param_r[`IDX_SPLINE_TYPE][1:0]);
  wire isep_on = param_r[`IDX_ISEP_ENABLE] == 16'h0001;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_r <= 1'b0;
      isep_eff_r <= 16'h0000;
      fb_mode_r <= 1'b1;
      sp_acc_r <= 1'b0;
      sp_vel_r <= 1'b0;
      sp_lin_r <= 1'b1;
      station_addr_r <= 8'h00;
      alias_valid_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r);
      isep_eff_r <= isep_on ? param_r[`IDX_ISEP_LIMIT] : 16'h0000;
      fb_mode_r <= param_r[`IDX_FIELDBUS_MODE][0];
      sp_acc_r <= spline_sel == SPLINE_ACCEL_CONT;
      sp_vel_r <= spline_sel == SPLINE_VEL_CONT;
      sp_lin_r <= spline_sel == SPLINE_LINEAR;
      station_addr_r <= pos_level_r ? 8'h00 : alias_active_r;
      alias_valid_r <= !pos_level_r && alias_active_r != 8'h00;
    end
  end

  assign O_AWREADY = awready_r;
  assign O_WREADY = wready_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_ARREADY = arready_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;
  assign O_NV_SAVE = nv_save_r;
  assign O_NV_ALIAS = nv_alias_r;
  assign O_STATION_ADDR = station_addr_r;
  assign O_ALIAS_ADDR_VALID = alias_valid_r;
  assign O_TRACK_GAIN = param_r[`IDX_TRACK_GAIN];
  assign O_TRACK_ITIME = param_r[`IDX_TRACK_ITIME];
  assign O_ISEP_LIMIT_EFF = isep_eff_r;
  assign O_VIB_DETECT_FREQ = param_r[`IDX_VIB_DETECT_FREQ];
  assign O_VIB_LOWPASS = param_r[`IDX_VIB_LOWPASS];
  assign O_VIB_HIGHPASS = param_r[`IDX_VIB_HIGHPASS];
  assign O_VIB_THRESHOLD = param_r[`IDX_VIB_THRESHOLD];
  assign O_VIB_SPEED_LEVEL = param_r[`IDX_VIB_SPEED_LEVEL];
  assign O_VIB_ALARM = vib_alarm_r;
  assign O_FIELDBUS_MODE = fb_mode_r;
  assign O_SPLINE_ACCEL_CONT = sp_acc_r;
  assign O_SPLINE_VEL_CONT = sp_vel_r;
  assign O_SPLINE_LINEAR = sp_lin_r;
  assign O_IRQ = irq_r;
endmodule

/* include/servo_param_bank_cfg.svh */
`ifndef SERVO_PARAM_BANK_CFG_SVH
`define SERVO_PARAM_BANK_CFG_SVH

// Parameter word indices; byte address is index times four
`define IDX_TRACK_GAIN 4'h0
`define IDX_TRACK_ITIME 4'h1
`define IDX_ISEP_LIMIT 4'h2
`define IDX_ISEP_ENABLE 4'h3
`define IDX_VIB_ALARM_TIME 4'h4
`define IDX_VIB_DETECT_FREQ 4'h5
`define IDX_VIB_LOWPASS 4'h6
`define IDX_VIB_HIGHPASS 4'h7
`define IDX_VIB_THRESHOLD 4'h8
`define IDX_VIB_SPEED_LEVEL 4'h9
`define IDX_STATION_ALIAS 4'hA
`define IDX_FIELDBUS_MODE 4'hB
`define IDX_SPLINE_TYPE 4'hC
`define NUM_PARAMS 13

// Bank control and status words
`define ADDR_CTRL 8'h40
`define ADDR_STATUS 8'h44
`define ADDR_MASK 8'h48
`define ADDR_ALIAS_ACTIVE 8'h4C
`define CTRL_SAVE_ALIAS_BIT 0
`define ST_REJECT_BIT 0
`define ST_VIB_ALARM_BIT 1
`define ST_ALIAS_SAVED_BIT 2
`define ST_WIDTH 3

// Reset values (integral time in tenths of a millisecond)
`define RST_TRACK_GAIN 16'h0028
`define RST_TRACK_ITIME 16'h00C8
`define RST_ISEP_LIMIT 16'h0000
`define RST_ISEP_ENABLE 16'h0000
`define RST_VIB_ALARM_TIME 16'h0006
`define RST_VIB_DETECT_FREQ 16'h0050
`define RST_VIB_LOWPASS 16'h0032
`define RST_VIB_HIGHPASS 16'h0064
`define RST_VIB_THRESHOLD 16'h001E
`define RST_VIB_SPEED_LEVEL 16'h0064
`define RST_STATION_ALIAS 16'h0000
`define RST_FIELDBUS_MODE 16'h0001
`define RST_SPLINE_TYPE 16'h0002
`define RST_MASK 3'h0

// Accepted ranges
`define MIN_TRACK_GAIN 16'sh0001
`define MAX_TRACK_GAIN 16'sh0BB8
`define MIN_TRACK_ITIME 16'sh000A
`define MAX_TRACK_ITIME 16'sh2710
`define MAX_PCT 16'sh0064
`define MAX_FLAG 16'sh0001
`define MAX_FREQ 16'sh07D0
`define MIN_HIGHPASS 16'sh000A
`define MAX_SPEED_LEVEL 16'sh00C8
`define MAX_STATION_ALIAS 16'sh0080
`define MAX_SPLINE_TYPE 16'sh0003
`define VIB_ALARM_OFF 16'h0064

// Alarm time: three counts per second
`define CLK_PERIOD_NS 8
`define VIB_UNIT_NS 1000000000
`define VIB_COUNTS_PER_UNIT 3
`define VIB_TICK_CYCLES ((`VIB_UNIT_NS / `CLK_PERIOD_NS) / `VIB_COUNTS_PER_UNIT)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

/* include/servo_param_bank_pkg.sv */
package servo_param_bank_pkg;
  typedef logic [15:0] param_word_t;
  typedef logic [1:0] axi_resp_t;
  typedef enum logic [1:0] {
    SPLINE_ACCEL_CONT,
    SPLINE_VEL_CONT,
    SPLINE_LINEAR,
    SPLINE_SPARE
  } spline_t;
endpackage

/* tb/servo_nv_store.sv */
`timescale 1ns/1ns
module servo_nv_store (
  input wire logic i_clk,
  input wire logic i_save,
  input wire logic [7:0] i_alias,
  output logic [7:0] o_alias
);
  // No reset: contents survive a power cycle
  initial o_alias = 8'h00;
  always @(posedge i_clk) begin
    if (i_save) begin
      o_alias <= i_alias;
    end
  end
endmodule

/* tb/servo_param_bank_bench.sv */
`timescale 1ns/1ns
`include "servo_param_bank_cfg.svh"
module servo_param_bank_bench;
  import servo_param_bank_pkg::*;
  localparam int TICK = 8;
  localparam axi_resp_t ok = `RESP_OKAY;
  localparam axi_resp_t se = `RESP_SLVERR;
  localparam axi_resp_t de = `RESP_DECERR;
  typedef struct {logic [7:0] a; logic [15:0] d; axi_resp_t r; logic [15:0] q;} row_t;
  row_t rows [29] = '{'{8'h00, 16'h0BB8, ok, 16'h0BB8}, '{8'h00, 16'h0BB9, se, 16'h0BB8},
    '{8'h00, 16'h0000, se, 16'h0BB8}, '{8'h00, 16'h0001, ok, 16'h0001},
    '{8'h00, 16'hFFFF, se, 16'h0001}, '{8'h04, 16'h000A, ok, 16'h000A},
    '{8'h04, 16'h0009, se, 16'h000A}, '{8'h04, 16'h2711, se, 16'h000A},
    '{8'h04, 16'h2710, ok, 16'h2710}, '{8'h08, 16'h0064, ok, 16'h0064},
    '{8'h08, 16'h0065, se, 16'h0064}, '{8'h0C, 16'h0001, ok, 16'h0001},
    '{8'h0C, 16'h0002, se, 16'h0001}, '{8'h10, 16'h0064, ok, 16'h0064},
    '{8'h10, 16'h0065, se, 16'h0064}, '{8'h14, 16'h0000, ok, 16'h0000},
    '{8'h14, 16'h07D1, se, 16'h0000}, '{8'h18, 16'h0000, se, 16'h0032},
    '{8'h18, 16'h07D0, ok, 16'h07D0}, '{8'h18, 16'h07D1, se, 16'h07D0},
    '{8'h1C, 16'h0009, se, 16'h0064}, '{8'h1C, 16'h000A, ok, 16'h000A},
    '{8'h28, 16'h0080, ok, 16'h0080}, '{8'h28, 16'h0081, se, 16'h0080},
    '{8'h2C, 16'h0000, ok, 16'h0000}, '{8'h2C, 16'h0002, se, 16'h0000},
    '{8'h30, 16'h0003, ok, 16'h0003}, '{8'h30, 16'h0004, se, 16'h0003},
    '{8'h50, 16'h1234, de, 16'h0000}};
  logic [15:0] defs [13] = '{16'h0028, 16'h00C8, 16'h0000, 16'h0000, 16'h0006, 16'h0050,
    16'h0032, 16'h0064, 16'h001E, 16'h0064, 16'h0000, 16'h0001, 16'h0002};
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, vib = 1'b0, pos_addr = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, nv_save, alias_valid, alarm, fb_mode;
  logic sp_acc, sp_vel, sp_lin, irq;
  axi_resp_t bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [7:0] nv_in, nv_out, st_addr;
  param_word_t gain, itime, isep, vdf, vlp, vhp, vth, vsl;
  int bad_count = 0, cmp_count = 0, cyc = 0;

  servo_param_bank #(.VIB_TICK_CYCLES(TICK)) servo_param_bank_i (.I_CORE_CLK(clk),
    .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_VIB_DETECTED(vib), .I_POSITION_ADDRESSING(pos_addr),
    .I_NV_ALIAS(nv_in), .O_NV_SAVE(nv_save), .O_NV_ALIAS(nv_out), .O_STATION_ADDR(st_addr),
    .O_ALIAS_ADDR_VALID(alias_valid), .O_TRACK_GAIN(gain), .O_TRACK_ITIME(itime),
    .O_ISEP_LIMIT_EFF(isep), .O_VIB_DETECT_FREQ(vdf), .O_VIB_LOWPASS(vlp),
    .O_VIB_HIGHPASS(vhp), .O_VIB_THRESHOLD(vth), .O_VIB_SPEED_LEVEL(vsl),
    .O_VIB_ALARM(alarm), .O_FIELDBUS_MODE(fb_mode), .O_SPLINE_ACCEL_CONT(sp_acc),
    .O_SPLINE_VEL_CONT(sp_vel), .O_SPLINE_LINEAR(sp_lin), .O_IRQ(irq));
  servo_nv_store servo_nv_store_i (.i_clk(clk), .i_save(nv_save), .i_alias(nv_out),
    .o_alias(nv_in));

  initial begin
    forever #4 clk = ~clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input axi_resp_t e, input axi_resp_t g);
    chk_word(nm, {30'h0, e}, {30'h0, g});
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic power_cycle;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(rows[i].a, {16'h0, rows[i].d});
      chk_resp("bresp", rows[i].r, rsp);
      axi_rd(rows[i].a);
      chk_word("rdata", {16'h0, rows[i].q}, rd);
      chk_resp("rresp", rows[i].a > 8'h4C ? de : ok, rsp);
    end
    settle;
    chk_word("gain", 32'h1, gain);
    chk_word("lp hp", {16'h07D0, 16'h000A}, {vlp, vhp});
    chk_word("df th", {16'h0000, 16'h001E}, {vdf, vth});
    chk_word("speed", 32'h64, vsl);
    chk_word("itime", 32'h2710, itime);
    chk_word("isep on", 32'h64, isep);
    chk_word("mode", 32'h0, fb_mode);
    chk_word("spline3", 32'h0, {sp_acc, sp_vel, sp_lin});
    chk_word("irq masked", 32'h0, irq);
    for (int s = 0; s < 3; s++) begin
      axi_wr(8'h30, s);
      settle;
      chk_word("spline", 3'b100 >> s, {sp_acc, sp_vel, sp_lin});
    end
    axi_wr(8'h2C, 32'h1);
    axi_wr(8'h0C, 32'h0);
    settle;
    chk_word("mode", 32'h1, fb_mode);
    chk_word("isep off", 32'h0, isep);
    axi_wr(`ADDR_MASK, 32'h7);
    settle;
    chk_word("irq", 32'h1, irq);
    axi_rd(`ADDR_STATUS);
    chk_word("status", 32'h1, rd);
    settle;
    chk_word("irq clr", 32'h0, irq);
    vib <= 1'b1;
    repeat (60) @(posedge clk);
    chk_word("alarm off", 32'h0, alarm);
    vib <= 1'b0;
    axi_wr(8'h10, 32'h3);
    vib <= 1'b1;
    repeat (12) @(posedge clk);
    chk_word("alarm early", 32'h0, alarm);
    repeat (30) @(posedge clk);
    chk_word("alarm", 32'h1, alarm);
    chk_word("irq vib", 32'h1, irq);
    axi_rd(`ADDR_STATUS);
    chk_word("status vib", 32'h2, rd);
    vib <= 1'b0;
    slow <= 1'b1;
    axi_wr(8'h28, 32'h5);
    axi_wr(`ADDR_CTRL, 32'h1);
    settle;
    chk_word("nv alias", 32'h5, nv_out);
    chk_word("addr unsaved", 32'h0, st_addr);
    axi_rd(`ADDR_STATUS);
    chk_word("status save", 32'h4, rd);
    power_cycle;
    settle;
    chk_word("addr", 32'h5, st_addr);
    chk_word("addr ok", 32'h1, alias_valid);
    axi_rd(`ADDR_ALIAS_ACTIVE);
    chk_word("alias act", 32'h5, rd);
    for (int i = 0; i < 13; i++) begin
      axi_rd(8'(i * 4));
      chk_word("default", {16'h0, defs[i]}, rd);
    end
    axi_rd(`ADDR_MASK);
    chk_word("mask", 32'h0, rd);
    pos_addr <= 1'b1;
    repeat (8) @(posedge clk);
    chk_word("pos addr", 32'h0, st_addr);
    chk_word("pos ok", 32'h0, alias_valid);
    wrap_up();
  end
endmodule

/* tb/servo_param_bank_monitor.sv */
`timescale 1ns/1ns
module servo_param_bank_monitor #(
  parameter int VIB_TICK_CYCLES = 8
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire servo_param_bank_pkg::axi_resp_t O_BRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic I_VIB_DETECTED,
  input wire logic O_VIB_ALARM,
  input wire logic I_POSITION_ADDRESSING,
  input wire logic [7:0] O_STATION_ADDR,
  input wire logic O_ALIAS_ADDR_VALID,
  input wire logic O_NV_SAVE,
  input wire logic [7:0] O_NV_ALIAS,
  input wire servo_param_bank_pkg::param_word_t O_TRACK_GAIN,
  input wire servo_param_bank_pkg::param_word_t O_TRACK_ITIME,
  input wire servo_param_bank_pkg::param_word_t O_VIB_LOWPASS,
  input wire servo_param_bank_pkg::param_word_t O_VIB_HIGHPASS,
  input wire logic O_SPLINE_ACCEL_CONT,
  input wire logic O_SPLINE_VEL_CONT,
  input wire logic O_SPLINE_LINEAR
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_b_wait; O_BVALID && !I_BREADY; endsequence
  sequence s_r_wait; O_RVALID && !I_RREADY; endsequence
  sequence s_pos_held; I_POSITION_ADDRESSING [*6]; endsequence
  sequence s_vib_quiet; !I_VIB_DETECTED [*6]; endsequence
  property p_bresp_hold; s_b_wait |=> O_BVALID && $stable(O_BRESP); endproperty
  property p_rdata_hold; s_r_wait |=> O_RVALID && $stable(O_RDATA); endproperty
  property p_gain_range; $signed(O_TRACK_GAIN) >= 1 && $signed(O_TRACK_GAIN) <= 3000; endproperty
  property p_itime_range; $signed(O_TRACK_ITIME) >= 10 && $signed(O_TRACK_ITIME) <= 10000;
  endproperty
  property p_lowpass_range; $signed(O_VIB_LOWPASS) >= 1 && $signed(O_VIB_LOWPASS) <= 2000;
  endproperty
  property p_highpass_range; $signed(O_VIB_HIGHPASS) >= 10 && $signed(O_VIB_HIGHPASS) <= 2000;
  endproperty
  property p_spline_decode; $onehot0({O_SPLINE_ACCEL_CONT, O_SPLINE_VEL_CONT, O_SPLINE_LINEAR});
  endproperty
  property p_pos_addr; s_pos_held |-> O_STATION_ADDR == 8'h00 && !O_ALIAS_ADDR_VALID; endproperty
  property p_alias_valid; O_ALIAS_ADDR_VALID |-> O_STATION_ADDR != 8'h00; endproperty
  property p_save_pulse;
    O_NV_SAVE |=> !O_NV_SAVE && $stable(O_NV_ALIAS) && $stable(O_STATION_ADDR);
  endproperty
  property p_vib_quiet; s_vib_quiet |-> !O_VIB_ALARM; endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write answer not held");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read answer not held");
  a_gain_range: assert property (p_gain_range) else $error("gain out of range");
  a_itime_range: assert property (p_itime_range) else $error("itime out of range");
  a_lowpass_range: assert property (p_lowpass_range) else $error("lowpass out of range");
  a_highpass_range: assert property (p_highpass_range) else $error("highpass bad");
  a_spline_decode: assert property (p_spline_decode) else $error("spline decode");
  a_pos_addr: assert property (p_pos_addr) else $error("alias used in positional mode");
  a_alias_valid: assert property (p_alias_valid) else $error("zero alias flagged usable");
  a_save_pulse: assert property (p_save_pulse) else $error("save pulse wrong");
  a_vib_quiet: assert property (p_vib_quiet) else $error("alarm without vibration");
endmodule

bind servo_param_bank servo_param_bank_monitor #(.VIB_TICK_CYCLES(VIB_TICK_CYCLES))
  servo_param_bank_monitor_i (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_RDATA(O_RDATA), .I_VIB_DETECTED(I_VIB_DETECTED), .O_VIB_ALARM(O_VIB_ALARM),
  .I_POSITION_ADDRESSING(I_POSITION_ADDRESSING), .O_STATION_ADDR(O_STATION_ADDR),
  .O_ALIAS_ADDR_VALID(O_ALIAS_ADDR_VALID), .O_NV_SAVE(O_NV_SAVE), .O_NV_ALIAS(O_NV_ALIAS),
  .O_TRACK_GAIN(O_TRACK_GAIN), .O_TRACK_ITIME(O_TRACK_ITIME), .O_VIB_LOWPASS(O_VIB_LOWPASS),
  .O_VIB_HIGHPASS(O_VIB_HIGHPASS), .O_SPLINE_ACCEL_CONT(O_SPLINE_ACCEL_CONT),
  .O_SPLINE_VEL_CONT(O_SPLINE_VEL_CONT), .O_SPLINE_LINEAR(O_SPLINE_LINEAR));
